// [hdl/ams_defines.vh]
`ifndef AMS_DEFINES_VH
`define AMS_DEFINES_VH

// Register addresses on the core register bus.
`define AMS_ADDR_PAIR_CFG     8'hba
`define AMS_ADDR_PORT3_SEL    8'hba
`define AMS_ADDR_CHAN_SEL     8'hbb
`define AMS_ADDR_AMP_CTRL     8'hd6
`define AMS_ADDR_CONV_CTRL    8'he8

// Page selection used to tell the two registers sharing one address apart.
`define AMS_PAGE_PAIR_CFG     1'b0
`define AMS_PAGE_PORT3_SEL    1'b1

// Field positions.
`define AMS_BIT_PORT3_DIFF    3
`define AMS_BIT_AMP_TWOS      2
`define AMS_BIT_AIN23_DIFF    1
`define AMS_BIT_AIN01_DIFF    0
`define AMS_BIT_AMP_EN        7
`define AMS_BIT_CONV_EN       7

// Reset values.
`define AMS_RST_REG8          8'h00
`define AMS_RST_REG4          4'h0

// Multiplexer positive input codes.
`define AMS_POS_AIN0          4'h0
`define AMS_POS_AIN1          4'h1
`define AMS_POS_AIN2          4'h2
`define AMS_POS_AIN3          4'h3
`define AMS_POS_AMP           4'h4
`define AMS_POS_AGND          4'h5
`define AMS_POS_EVEN          4'h6
`define AMS_POS_ODD           4'h7
`define AMS_POS_TEMP          4'h8
`define AMS_POS_NONE          4'hf

// Multiplexer negative input codes.
`define AMS_NEG_AGND          3'h0
`define AMS_NEG_AIN1          3'h1
`define AMS_NEG_AIN3          3'h2
`define AMS_NEG_AMP_REF       3'h3
`define AMS_NEG_ODD           3'h4
`define AMS_NEG_NONE          3'h7

`endif

// [hdl/ams_adc_input_mux_select.v]
// Overview of operation
// - Pair config upper nibble reads zero, ignores writes.
// - Bit3 makes even/odd port pins differential.
// - Bit2 measures amplifier against reference, signed.
// - Bit1 pairs inputs two and three differential.
// - Bit0 pairs inputs zero and one differential.
// - Differential channels give two's-complement results.
// - Channel code with config bits selects input.
// - Odd code of differential pair selects nothing.
// - Pin-select bit n connects port pin n.
// - Enabled even/odd pins wired-OR onto inputs.
// - Amplifier gain field spans 0.05 to 14.
// - Amplifier to positive; reference to negative input only when bit2 is set, AGND otherwise.
// - Amplifier control bit7 enables; resets to zero.
// - Reset single-ended; converter runs only when enabled.
`timescale 1ns/1ps
`default_nettype none
`include "ams_defines.vh"

module ams_adc_input_mux_select #(
    parameter PIN_COUNT = 8
) (
    input  wire                 sys_clk,
    input  wire                 srst,
    input  wire [7:0]           reg_addr,
    input  wire                 reg_page,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    input  wire [7:0]           reg_wdata,
    output reg  [7:0]           reg_rdata,
    output reg  [3:0]           mux_pos_sel,
    output reg  [2:0]           mux_neg_sel,
    output reg                  mux_valid,
    output reg                  result_twos_comp,
    output reg  [PIN_COUNT-1:0] even_pin_input,
    output reg  [PIN_COUNT-1:0] odd_pin_input,
    output reg                  amp_enable_bit,
    output reg  [2:0]           amp_gain_field,
    output reg                  converter_active
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register file.

    reg [3:0]           input_pair_config_r;
    reg [3:0]           channel_code_r;
    reg [PIN_COUNT-1:0] port3_analog_pin_select_r;
    reg [7:0]           amp_control_reg_r;
    reg                 converter_enable_bit_r;

    wire sel_pair  = (reg_addr == `AMS_ADDR_PAIR_CFG) && (reg_page == `AMS_PAGE_PAIR_CFG);
    wire sel_port3 = (reg_addr == `AMS_ADDR_PORT3_SEL) && (reg_page == `AMS_PAGE_PORT3_SEL);
    wire sel_chan  = (reg_addr == `AMS_ADDR_CHAN_SEL);
    wire sel_amp   = (reg_addr == `AMS_ADDR_AMP_CTRL);
    wire sel_conv  = (reg_addr == `AMS_ADDR_CONV_CTRL);

    always @(posedge sys_clk) begin
        if (srst) begin
            input_pair_config_r       <= `AMS_RST_REG4;
            channel_code_r            <= `AMS_RST_REG4;
            port3_analog_pin_select_r <= {PIN_COUNT{1'b0}};
            amp_control_reg_r         <= `AMS_RST_REG8;
            converter_enable_bit_r    <= 1'b0;
        end else if (reg_wr) begin
            if (sel_pair) begin
                input_pair_config_r <= reg_wdata[3:0];
            end
            if (sel_chan) begin
                channel_code_r <= reg_wdata[3:0];
            end
            if (sel_port3) begin
                port3_analog_pin_select_r <= reg_wdata[PIN_COUNT-1:0];
            end
            if (sel_amp) begin
                // Bits 6 to 3 are reserved and stay zero.
                amp_control_reg_r <= {reg_wdata[`AMS_BIT_AMP_EN], 4'h0, reg_wdata[2:0]};
            end
            if (sel_conv) begin
                converter_enable_bit_r <= reg_wdata[`AMS_BIT_CONV_EN];
            end
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= `AMS_RST_REG8;
        end else if (reg_rd) begin
            if (sel_pair) begin
                reg_rdata <= {4'h0, input_pair_config_r};
            end else if (sel_port3) begin
                reg_rdata <= port3_analog_pin_select_r;
            end else if (sel_chan) begin
                reg_rdata <= {4'h0, channel_code_r};
            end else if (sel_amp) begin
                reg_rdata <= amp_control_reg_r;
            end else if (sel_conv) begin
                reg_rdata <= {converter_enable_bit_r, 7'h00};
            end else begin
                reg_rdata <= `AMS_RST_REG8;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Selection decode.

    wire even_odd_pair_diff    = input_pair_config_r[`AMS_BIT_PORT3_DIFF];
    wire amp_twos_comp_select  = input_pair_config_r[`AMS_BIT_AMP_TWOS];
    wire inputs_two_three_diff = input_pair_config_r[`AMS_BIT_AIN23_DIFF];
    wire inputs_zero_one_diff  = input_pair_config_r[`AMS_BIT_AIN01_DIFF];

    reg [3:0] pos_nxt;
    reg [2:0] neg_nxt;
    reg       valid_nxt;
    reg       diff_nxt;

    always @* begin
        pos_nxt   = `AMS_POS_NONE;
        neg_nxt   = `AMS_NEG_AGND;
        valid_nxt = 1'b1;
        diff_nxt  = 1'b0;
        if (channel_code_r[3]) begin
            pos_nxt = `AMS_POS_TEMP;
        end else begin
            case (channel_code_r[2:0])
                3'h0: begin
                    pos_nxt = `AMS_POS_AIN0;
                    if (inputs_zero_one_diff) begin
                        neg_nxt  = `AMS_NEG_AIN1;
                        diff_nxt = 1'b1;
                    end
                end
                3'h1: begin
                    pos_nxt = `AMS_POS_AIN1;
                    valid_nxt = ~inputs_zero_one_diff;
                end
                3'h2: begin
                    pos_nxt = `AMS_POS_AIN2;
                    if (inputs_two_three_diff) begin
                        neg_nxt  = `AMS_NEG_AIN3;
                        diff_nxt = 1'b1;
                    end
                end
                3'h3: begin
                    pos_nxt = `AMS_POS_AIN3;
                    valid_nxt = ~inputs_two_three_diff;
                end
                3'h4: begin
                    pos_nxt = `AMS_POS_AMP;
                    if (amp_twos_comp_select) begin
                        neg_nxt  = `AMS_NEG_AMP_REF;
                        diff_nxt = 1'b1;
                    end
                end
                3'h5: begin
                    pos_nxt = `AMS_POS_AGND;
                    valid_nxt = ~amp_twos_comp_select;
                end
                3'h6: begin
                    pos_nxt = `AMS_POS_EVEN;
                    if (even_odd_pair_diff) begin
                        neg_nxt  = `AMS_NEG_ODD;
                        diff_nxt = 1'b1;
                    end
                end
                3'h7: begin
                    pos_nxt = `AMS_POS_ODD;
                    valid_nxt = ~even_odd_pair_diff;
                end
                default: begin
                    pos_nxt = `AMS_POS_NONE;
                end
            endcase
        end
        if (!valid_nxt) begin
            pos_nxt = `AMS_POS_NONE;
            neg_nxt = `AMS_NEG_NONE;
            diff_nxt = 1'b0;
        end
    end

    // Even pins land on the even input and odd pins on the odd input.
    wire [PIN_COUNT-1:0] even_mask;
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
            assign even_mask[gi] = ((gi % 2) == 0);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Registered switch controls.

    always @(posedge sys_clk) begin
        if (srst) begin
            mux_pos_sel      <= `AMS_POS_AIN0;
            mux_neg_sel      <= `AMS_NEG_AGND;
            mux_valid        <= 1'b1;
            result_twos_comp <= 1'b0;
            even_pin_input   <= {PIN_COUNT{1'b0}};
            odd_pin_input    <= {PIN_COUNT{1'b0}};
            amp_enable_bit   <= 1'b0;
            amp_gain_field   <= 3'h0;
            converter_active <= 1'b0;
        end else begin
            mux_pos_sel      <= pos_nxt;
            mux_neg_sel      <= neg_nxt;
            mux_valid        <= valid_nxt;
            result_twos_comp <= diff_nxt;
            even_pin_input   <= port3_analog_pin_select_r & even_mask;
            odd_pin_input    <= port3_analog_pin_select_r & ~even_mask;
            amp_enable_bit   <= amp_control_reg_r[`AMS_BIT_AMP_EN];
            amp_gain_field   <= amp_control_reg_r[2:0];
            converter_active <= converter_enable_bit_r;
        end
    end

endmodule
`default_nettype wire

// [test/ams_mux_sel_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ams_mux_sel_props #(
    parameter PIN_COUNT = 8
) (
    input wire logic                 sys_clk,
    input wire logic                 srst,
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_page,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_wdata,
    input wire logic [7:0]           reg_rdata,
    input wire logic [3:0]           mux_pos_sel,
    input wire logic [2:0]           mux_neg_sel,
    input wire logic                 mux_valid,
    input wire logic                 result_twos_comp,
    input wire logic [PIN_COUNT-1:0] even_pin_input,
    input wire logic [PIN_COUNT-1:0] odd_pin_input,
    input wire logic                 amp_enable_bit,
    input wire logic [2:0]           amp_gain_field,
    input wire logic                 converter_active
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    //////////////////////////////////////////////////////////////////////////
    // Amplifier and converter writes are followed by a quiet cycle, so the new value is the one seen; the pin write is a single cycle.
    sequence s_amp_wr;
        reg_wr && reg_addr == 8'hd6 ##1 !(reg_wr && reg_addr == 8'hd6);
    endsequence
    sequence s_conv_wr;
        reg_wr && reg_addr == 8'he8 ##1 !(reg_wr && reg_addr == 8'he8);
    endsequence
    sequence s_pin_wr;
        reg_wr && reg_addr == 8'hba && reg_page;
    endsequence
    a_nibble_reads_zero: assert property (reg_rd && reg_addr == 8'hba && !reg_page |=>
        reg_rdata[7:4] == 4'h0)
        else $error("pair config upper nibble not zero");
    a_even_pins_follow: assert property (s_pin_wr |-> ##2
        even_pin_input == ($past(reg_wdata, 2) & 8'h55))
        else $error("even pin enables wrong");
    a_odd_pins_follow: assert property (s_pin_wr |-> ##2
        odd_pin_input == ($past(reg_wdata, 2) & 8'haa))
        else $error("odd pin enables wrong");
    a_amp_ctrl_follow: assert property (s_amp_wr |=>
        {amp_enable_bit, 4'h0, amp_gain_field} == ($past(reg_wdata, 2) & 8'h87))
        else $error("amplifier control wrong");
    a_conv_en_follow: assert property (s_conv_wr |=>
        {converter_active, 7'h0} == ($past(reg_wdata, 2) & 8'h80))
        else $error("converter enable wrong");
    a_reset_single_ended: assert property (disable iff (1'b0) $fell(srst) |->
        mux_valid && !result_twos_comp)
        else $error("not single ended after reset");
    a_odd_code_void: assert property (!mux_valid |->
        mux_pos_sel == 4'hf && mux_neg_sel == 3'h7 && !result_twos_comp)
        else $error("void selection drives an input");
    a_twos_when_diff: assert property (mux_valid |-> result_twos_comp == (mux_neg_sel != 3'h0))
        else $error("result format does not match pairing");
    a_update_latency: assert property (!$stable(mux_pos_sel) |->
        $past(reg_wr, 2) || $past(srst) || $past(srst, 2))
        else $error("selection changed without a write");
endmodule

bind ams_adc_input_mux_select ams_mux_sel_props #(.PIN_COUNT(PIN_COUNT)) u_props (
    .sys_clk, .srst, .reg_addr, .reg_page, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mux_pos_sel,
    .mux_neg_sel, .mux_valid, .result_twos_comp, .even_pin_input, .odd_pin_input, .amp_enable_bit,
    .amp_gain_field, .converter_active
);
`default_nettype wire

// [test/ams_adc_input_mux_select_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module ams_adc_input_mux_select_tb_top;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_page = 1'b0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [3:0] mux_pos_sel;
    logic [2:0] mux_neg_sel;
    logic       mux_valid;
    logic       result_twos_comp;
    logic [7:0] even_pin_input;
    logic [7:0] odd_pin_input;
    logic       amp_enable_bit;
    logic [2:0] amp_gain_field;
    logic       converter_active;
    logic [7:0] d;
    int         fails = 0;
    int         comparisons = 0;

    always #2.5 sys_clk = ~sys_clk;

    ams_adc_input_mux_select #(.PIN_COUNT(8)) dut (
        .sys_clk, .srst, .reg_addr, .reg_page, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mux_pos_sel,
        .mux_neg_sel, .mux_valid, .result_twos_comp, .even_pin_input, .odd_pin_input, .amp_enable_bit,
        .amp_gain_field, .converter_active
    );
    //////////////////////////////////////////////////////////////////////////
    // Packs {twos, valid, negative, positive}; the odd code of a paired input selects nothing.
    function automatic logic [8:0] exp_mux(input logic [3:0] cfg, input logic [3:0] code);
        if (code[3]) return 9'h088;
        if (!cfg[code[2:1]]) return {5'h08, code};
        if (code[0]) return 9'h07f;
        return {2'b11, 3'(code[2:1]) + 3'h1, code};
    endfunction
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_mux(input logic [3:0] cfg, input logic [3:0] code);
        chk("mux", {7'h0, exp_mux(cfg, code)}, {7'h0, result_twos_comp, mux_valid, mux_neg_sel, mux_pos_sel});
    endtask
    // The second edge lets the decoded outputs settle before anyone looks.
    task automatic wr(input logic [7:0] a, input logic p, input logic [7:0] v);
        reg_addr = a;
        reg_page = p;
        reg_wdata = v;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic p, input logic [7:0] v);
        reg_addr = a;
        reg_page = p;
        reg_rd = 1'b1;
        tick();
        chk("read data", {8'h0, v}, {8'h0, reg_rdata});
        reg_rd = 1'b0;
        tick();
    endtask
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    initial begin
        void'($urandom(30));
        repeat (8) @(posedge sys_clk);
        #1 srst = 1'b0;
        chk_mux(4'h0, 4'h0);
        rd(8'hba, 1'b0, 8'h00);
        rd(8'hba, 1'b1, 8'h00);
        rd(8'hbb, 1'b0, 8'h00);
        rd(8'hd6, 1'b0, 8'h00);
        for (int c = 0; c < 16; c++) begin
            wr(8'hba, 1'b0, {4'($urandom), 4'(c)});
            rd(8'hba, 1'b0, {4'h0, 4'(c)});
            for (int k = 0; k < 16; k++) begin
                wr(8'hbb, 1'b0, {4'($urandom), 4'(k)});
                chk_mux(4'(c), 4'(k));
            end
        end
        rd(8'hbb, 1'b0, 8'h0f);
        for (int i = 0; i < 16; i++) begin
            d = (i == 0) ? 8'hff : 8'($urandom);
            wr(8'hba, 1'b1, d);
            chk("even pins", {8'h0, d & 8'h55}, {8'h0, even_pin_input});
            chk("odd pins", {8'h0, d & 8'haa}, {8'h0, odd_pin_input});
            rd(8'hba, 1'b1, d);
        end
        rd(8'hba, 1'b0, 8'h0f);
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'h80 : 8'($urandom);
            wr(8'hd6, 1'b0, d);
            chk("amp ctrl", {12'h0, d[7], d[2:0]}, {12'h0, amp_enable_bit, amp_gain_field});
            rd(8'hd6, 1'b0, d & 8'h87);
        end
        wr(8'he8, 1'b0, 8'h80);
        chk("conv en", 16'h1, {15'h0, converter_active});
        wr(8'he8, 1'b0, 8'h00);
        chk("conv en", 16'h0, {15'h0, converter_active});
        wr(8'h55, 1'b0, 8'hff);
        rd(8'h55, 1'b0, 8'h00);
        // Leave every register non-zero so the mid-run reset has something to clear.
        wr(8'hd6, 1'b0, 8'h87);
        wr(8'he8, 1'b0, 8'h80);
        srst = 1'b1;
        tick();
        srst = 1'b0;
        tick();
        chk_mux(4'h0, 4'h0);
        chk("pins", 16'h0, {even_pin_input, odd_pin_input});
        chk("amp conv", 16'h0, {11'h0, amp_enable_bit, amp_gain_field, converter_active});
        rd(8'hba, 1'b0, 8'h00);
        rd(8'hbb, 1'b0, 8'h00);
        rd(8'hd6, 1'b0, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
